/* File: verilog/uwc_wiper_ctrl.sv */
// wiper position counter, tap decoder and nonvolatile store control
//
// Behaviour
// - direction level chooses up or down
// - falling step edge moves one tap
// - steps honoured only while selected
// - deselect with strobe high stores count
// - after store, standby until reselected
// - seven-bit count, one of 100 taps
// - exactly one tap switch enabled
// - count saturates at both ends
// - power-up recalls last stored value
// - direction may change within one selection
`timescale 1ns/10ps

module uwc_wiper_ctrl #(
  parameter int unsigned STORE_CYCLES = uwc_pkg::STORE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire uwc_pkg::uwc_pins_t i_pins,
  input wire logic [uwc_pkg::CNT_W-1:0] i_nv_rd_data,
  output logic [uwc_pkg::CNT_W-1:0] o_count,
  output logic [uwc_pkg::TAP_N-1:0] o_tap_sel,
  output logic o_standby,
  output logic o_nv_wr_en,
  output logic [uwc_pkg::CNT_W-1:0] o_nv_wr_data
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [uwc_pkg::TAP_N-1:0] tap_decode(
    input logic [uwc_pkg::CNT_W-1:0] c
  );
    tap_decode = {{(uwc_pkg::TAP_N-1){1'b0}}, 1'b1} << c;
  endfunction : tap_decode

  function automatic logic [uwc_pkg::CNT_W-1:0] clamp_count(
    input logic [uwc_pkg::CNT_W-1:0] c
  );
    // a corrupt stored word must not select a missing tap
    clamp_count = (c > uwc_pkg::CNT_MAX) ? uwc_pkg::CNT_MAX : c;
  endfunction : clamp_count

  localparam logic [uwc_pkg::TMR_W-1:0] STORE_LOAD =
    uwc_pkg::TMR_W'(STORE_CYCLES) - uwc_pkg::TMR_ONE;

  // ****************************************************************
  // edge detection
  // ****************************************************************
  logic inc_prev_q;
  logic cs_prev_q;
  uwc_pkg::uwc_state_t state_q;
  uwc_pkg::uwc_state_t state_d;
  logic [uwc_pkg::CNT_W-1:0] count_q;
  logic [uwc_pkg::CNT_W-1:0] count_d;
  logic [uwc_pkg::TMR_W-1:0] timer_q;
  logic inc_fall;
  logic cs_rise;
  logic step;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      inc_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      inc_prev_q <= i_pins.inc_n;
      cs_prev_q <= i_pins.cs_n;
    end
  end

  assign inc_fall = inc_prev_q & ~i_pins.inc_n;
  assign cs_rise = ~cs_prev_q & i_pins.cs_n;
  // a step on the same cycle as the select edge is dropped
  assign step = (state_q == uwc_pkg::ST_ACTIVE) & ~i_pins.cs_n &
                inc_fall;

  // ****************************************************************
  // control state machine
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      uwc_pkg::ST_RECALL: begin
        state_d = uwc_pkg::ST_STANDBY;
      end
      uwc_pkg::ST_STANDBY: begin
        if (!i_pins.cs_n) begin
          state_d = uwc_pkg::ST_ACTIVE;
        end
      end
      uwc_pkg::ST_ACTIVE: begin
        if (cs_rise) begin
          if (i_pins.inc_n) begin
            state_d = uwc_pkg::ST_STORE;
          end else begin
            state_d = uwc_pkg::ST_STANDBY;
          end
        end
      end
      uwc_pkg::ST_STORE: begin
        // inputs are ignored until the write is done
        if (timer_q == uwc_pkg::TMR_ZERO) begin
          state_d = uwc_pkg::ST_STANDBY;
        end
      end
      default: begin
        state_d = uwc_pkg::ST_RECALL;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= uwc_pkg::ST_RECALL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_q <= uwc_pkg::TMR_ZERO;
    end else if (state_q != uwc_pkg::ST_STORE) begin
      timer_q <= STORE_LOAD;
    end else if (timer_q != uwc_pkg::TMR_ZERO) begin
      timer_q <= timer_q - uwc_pkg::TMR_ONE;
    end
  end

  // ****************************************************************
  // position counter
  // ****************************************************************
  always_comb begin
    count_d = count_q;
    if (state_q == uwc_pkg::ST_RECALL) begin
      count_d = clamp_count(i_nv_rd_data);
    end else if (step) begin
      if (i_pins.up_dn) begin
        if (count_q != uwc_pkg::CNT_MAX) begin
          count_d = count_q + uwc_pkg::CNT_ONE;
        end
      end else if (count_q != uwc_pkg::CNT_MIN) begin
        count_d = count_q - uwc_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= uwc_pkg::CNT_RST;
      o_tap_sel <= tap_decode(uwc_pkg::CNT_RST);
    end else begin
      count_q <= count_d;
      o_tap_sel <= tap_decode(count_d);
    end
  end

  assign o_count = count_q;

  // ****************************************************************
  // nonvolatile store and standby
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_nv_wr_en <= 1'b0;
      o_nv_wr_data <= uwc_pkg::CNT_RST;
      o_standby <= 1'b0;
    end else begin
      o_nv_wr_en <= (state_d == uwc_pkg::ST_STORE);
      if (state_q == uwc_pkg::ST_ACTIVE &&
          state_d == uwc_pkg::ST_STORE) begin
        o_nv_wr_data <= count_q;
      end
      o_standby <= (state_d == uwc_pkg::ST_STANDBY);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_step_up;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    step && i_pins.up_dn && count_q != uwc_pkg::CNT_MAX
      |=> count_q == $past(count_q) + uwc_pkg::CNT_ONE;
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("step up did not add one");

  property p_step_dn;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    step && !i_pins.up_dn && count_q != uwc_pkg::CNT_MIN
      |=> count_q == $past(count_q) - uwc_pkg::CNT_ONE;
  endproperty
  a_step_dn: assert property (p_step_dn)
    else $error("step down did not subtract one");

  property p_move_cause;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    $changed(count_q) |->
      $past(inc_fall) && $past(state_q) != uwc_pkg::ST_STORE ||
      $past(state_q) == uwc_pkg::ST_RECALL;
  endproperty
  a_move_cause: assert property (p_move_cause)
    else $error("count moved without a strobe edge");

  property p_unselected;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    i_pins.cs_n && state_q != uwc_pkg::ST_RECALL |=> $stable(count_q);
  endproperty
  a_unselected: assert property (p_unselected)
    else $error("count moved while deselected");

  property p_store_start;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    state_q == uwc_pkg::ST_ACTIVE && cs_rise && i_pins.inc_n
      |=> o_nv_wr_en && o_nv_wr_data == $past(count_q);
  endproperty
  a_store_start: assert property (p_store_start)
    else $error("storing deselect did not start a write");

  property p_store_hold;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_nv_wr_en ##1 o_nv_wr_en |-> $stable(o_nv_wr_data) && $stable(count_q);
  endproperty
  a_store_hold: assert property (p_store_hold)
    else $error("store data changed during write");

  property p_store_end;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    state_q == uwc_pkg::ST_STORE && timer_q == uwc_pkg::TMR_ZERO
      |=> o_standby && !o_nv_wr_en;
  endproperty
  a_store_end: assert property (p_store_end)
    else $error("no standby after store");

  property p_standby_hold;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    o_standby && i_pins.cs_n |=> o_standby;
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("left standby while deselected");

  property p_no_store;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    state_q == uwc_pkg::ST_ACTIVE && cs_rise && !i_pins.inc_n
      |=> o_standby && !o_nv_wr_en;
  endproperty
  a_no_store: assert property (p_no_store)
    else $error("non-storing deselect wrote memory");

  property p_tap;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    $onehot(o_tap_sel) && o_tap_sel[o_count] &&
      o_count <= uwc_pkg::CNT_MAX;
  endproperty
  a_tap: assert property (p_tap)
    else $error("tap select not matching count");

  property p_sat;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    step && (i_pins.up_dn ? count_q == uwc_pkg::CNT_MAX :
             count_q == uwc_pkg::CNT_MIN) |=> $stable(count_q);
  endproperty
  a_sat: assert property (p_sat)
    else $error("count wrapped at an end");

  property p_recall;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    state_q == uwc_pkg::ST_RECALL
      |=> count_q == clamp_count($past(i_nv_rd_data)) ##1 o_standby;
  endproperty
  a_recall: assert property (p_recall)
    else $error("power-up recall failed");

  c_step_up: cover property (@(posedge i_clk_sys) step && i_pins.up_dn);
  c_store: cover property (@(posedge i_clk_sys)
    o_nv_wr_en ##1 !o_nv_wr_en);
  c_no_store: cover property (@(posedge i_clk_sys)
    state_q == uwc_pkg::ST_ACTIVE && cs_rise && !i_pins.inc_n);
  c_top: cover property (@(posedge i_clk_sys)
    step && count_q == uwc_pkg::CNT_MAX);

endmodule : uwc_wiper_ctrl

/* File: verilog/uwc_pkg.sv */
// shared constants and types for the wiper counter control section
package uwc_pkg;

  // ****************************************************************
  // counter and tap geometry
  // ****************************************************************
  localparam int unsigned CNT_W = 7;
  localparam int unsigned TAP_N = 100;
  localparam logic [CNT_W-1:0] CNT_MIN = 7'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h63;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [CNT_W-1:0] CNT_RST = 7'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned NS_PER_MS = 1000000;
  // least deselect time after a storing deselect, in ms
  localparam int unsigned STORE_DESELECT_TIME_MS = 20;
  // longest time a store may occupy, rounded down to cycles
  localparam int unsigned STORE_CYC =
    (STORE_DESELECT_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 32;
  localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 32'h0000_0001;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic cs_n;   // device select, active low
    logic inc_n;  // step strobe, acts on falling edge
    logic up_dn;  // direction: high moves up
  } uwc_pins_t;

  typedef enum logic [3:0] {
    ST_RECALL  = 4'b0001,
    ST_ACTIVE  = 4'b0010,
    ST_STORE   = 4'b0100,
    ST_STANDBY = 4'b1000
  } uwc_state_t;

endpackage : uwc_pkg

/* File: test/uwc_host_model.sv */
// host side model driving select, step and direction pins
`timescale 1ns/10ps

module uwc_host_model (
  input wire logic i_clk_sys,
  output uwc_pkg::uwc_pins_t o_pins
);
  // ****************************************************************
  // pin drive, all changes at the falling edge
  // ****************************************************************
  // select and strobe start high before reset lifts
  initial begin
    o_pins = '{cs_n: 1'b1, inc_n: 1'b1, up_dn: 1'b1};
  end

  // entry cycle drops a fall, so wait two cycles before stepping
  task automatic sel();
    @(negedge i_clk_sys) o_pins.cs_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
  endtask : sel

  // direction settles a cycle before the fall, away from select edges
  task automatic step(input logic up);
    @(negedge i_clk_sys) o_pins.up_dn = up;
    @(negedge i_clk_sys) o_pins.inc_n = 1'b0;
    @(negedge i_clk_sys);
    @(negedge i_clk_sys) o_pins.inc_n = 1'b1;
    @(negedge i_clk_sys);
  endtask : step

  // strobe high while select rises requests a store
  task automatic desel_store();
    @(negedge i_clk_sys) o_pins.cs_n = 1'b1;
  endtask : desel_store

  // last step keeps strobe low across the select rise
  task automatic desel_keep(input logic up);
    @(negedge i_clk_sys) o_pins.up_dn = up;
    @(negedge i_clk_sys) o_pins.inc_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    o_pins.cs_n = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    o_pins.inc_n = 1'b1;
    @(negedge i_clk_sys);
  endtask : desel_keep

  // strobe pulse with select left as it is
  task automatic toggle_inc();
    @(negedge i_clk_sys) o_pins.inc_n = 1'b0;
    @(negedge i_clk_sys) o_pins.inc_n = 1'b1;
  endtask : toggle_inc
endmodule : uwc_host_model

/* File: test/uwc_wiper_ctrl_tb.sv */
// self-checking bench for the wiper counter control section
`timescale 1ns/10ps

module uwc_wiper_ctrl_tb;
  localparam int unsigned STORE_N = 8;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  uwc_pkg::uwc_pins_t pins;
  // nonvolatile word survives reset, as the real array does
  logic [uwc_pkg::CNT_W-1:0] nv_q = 7'h05;
  // word past the last tap, as a damaged array could return
  localparam logic [uwc_pkg::CNT_W-1:0] NV_BAD = 7'h7F;
  logic nv_spoil = 1'b0;
  logic [uwc_pkg::CNT_W-1:0] o_count;
  logic [uwc_pkg::TAP_N-1:0] o_tap_sel;
  logic o_standby;
  logic o_nv_wr_en;
  logic [uwc_pkg::CNT_W-1:0] o_nv_wr_data;
  int err_total = 0;
  int num_checks = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;
  // the stored word moves only at the falling edge, like every input
  always @(negedge i_clk_sys) begin
    if (o_nv_wr_en === 1'b1) begin
      nv_q <= o_nv_wr_data;
    end else if (nv_spoil) begin
      nv_q <= NV_BAD;
    end
  end

  uwc_host_model host (.i_clk_sys(i_clk_sys), .o_pins(pins));
  uwc_wiper_ctrl #(.STORE_CYCLES(STORE_N)) dut (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_pins(pins),
    .i_nv_rd_data(nv_q), .o_count(o_count), .o_tap_sel(o_tap_sel),
    .o_standby(o_standby), .o_nv_wr_en(o_nv_wr_en),
    .o_nv_wr_data(o_nv_wr_data));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string what, input logic [99:0] seen,
                       input logic [99:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic check_pos(input logic [uwc_pkg::CNT_W-1:0] n);
    check("count", 100'(o_count), 100'(n));
    check("tap_sel", o_tap_sel, {{99{1'b0}}, 1'b1} << n);
  endtask : check_pos

  task automatic complete_run();
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic do_reset(input logic [uwc_pkg::CNT_W-1:0] exp);
    @(negedge i_clk_sys) i_reset_n = 1'b0;
    repeat (10) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    check_pos(exp);
    check("standby", 100'(o_standby), 100'(1));
  endtask : do_reset

  task automatic t_updown();
    host.sel();
    check("standby sel", 100'(o_standby), 100'(0));
    for (int i = 6; i <= 8; i++) begin
      host.step(1'b1);
      check_pos(7'(i));
    end
    host.step(1'b0);
    check_pos(7'h07);
  endtask : t_updown

  task automatic t_saturate();
    repeat (8) host.step(1'b0);
    check_pos(7'h00);
    repeat (100) host.step(1'b1);
    check_pos(7'h63);
  endtask : t_saturate

  task automatic t_keep();
    host.desel_keep(1'b0);
    repeat (STORE_N + 2) @(negedge i_clk_sys);
    check_pos(7'h62);
    check("standby keep", 100'(o_standby), 100'(1));
    check("nv keep", 100'(nv_q), 100'(7'h05));
    repeat (2) host.toggle_inc();
    check_pos(7'h62);
  endtask : t_keep

  task automatic t_store();
    int n;
    n = 0;
    host.sel();
    host.step(1'b0);
    host.desel_store();
    fork
      repeat (3) host.toggle_inc();
      repeat (STORE_N + 8) begin
        @(negedge i_clk_sys);
        if (o_nv_wr_en === 1'b1) begin
          n++;
          check("wr_data", 100'(o_nv_wr_data), 100'(7'h61));
          check("standby wr", 100'(o_standby), 100'(0));
        end
      end
    join
    check("wr_len", 100'(n), 100'(STORE_N));
    check("standby end", 100'(o_standby), 100'(1));
    check_pos(7'h61);
    // select high for the full store time before anything else
    repeat (STORE_N) @(negedge i_clk_sys);
  endtask : t_store

  // a stored word past the last tap must come back as the top tap
  task automatic t_spoil();
    @(negedge i_clk_sys) nv_spoil = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    nv_spoil = 1'b0;
    do_reset(uwc_pkg::CNT_MAX);
  endtask : t_spoil

  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  initial begin
    do_reset(7'h05);
    t_updown();
    t_saturate();
    t_keep();
    t_store();
    do_reset(7'h61);
    t_spoil();
    complete_run();
  end
endmodule : uwc_wiper_ctrl_tb
